// ### src/startup_option_registers.sv
// write-once startup option registers on an AHB-Lite slave
//
// What this block does
// - each register accepts one write per reset
// - reset clears both registers to zero
// - registers read back at any time
// - registers decoded at indices 1F and 3F
// - monitor runs in stop when bit set
// - reset-block bit stops monitor reset requests
// - power-off bit switches monitor off
// - stop wake delay 32 or 4096 cycles
// - watchdog timeout selects long or short
// - stop instruction legal only when enabled
// - watchdog-off bit disables watchdog
// - divider clock select bus or oscillator
//
// Local design decisions: the register offsets and the AHB-Lite slave port.
`timescale 1ns/1ps
`include "option_regs_map.svh"

module startup_option_registers (
   input  wire logic                         hclk,
   input  wire logic                         hresetn,
   input  wire logic                         hsel,
   input  wire logic [31:0]                  haddr,
   input  wire logic [1:0]                   htrans,
   input  wire logic                         hwrite,
   input  wire logic [2:0]                   hsize,
   input  wire logic [31:0]                  hwdata,
   input  wire logic                         hready,
   output logic      [31:0]                  hrdata,
   output logic                              hreadyout,
   output logic                              hresp,
   input  wire logic                         stop_mode,
   input  wire logic                         lowvolt_reset_req,
   output logic                              lowvolt_monitor_run,
   output logic                              lowvolt_reset_out,
   output logic                              watchdog_enable,
   output logic      [18:0]                  watchdog_timeout,
   output logic      [12:0]                  wake_delay,
   output logic                              stop_legal,
   output logic                              nvm_div_use_bus_clk
);
   import option_regs_pkg::*;

   // ==========================================================
   // bus front end
   // ==========================================================
   bus_state_type st_q, st_d;
   logic          wr_q, wr_d;
   logic [1:0]    sel_q, sel_d;
   opt_byte_type  one_q, one_d, two_q, two_d;
   logic          one_lock_q, one_lock_d, two_lock_q, two_lock_d;
   logic [31:0]   rdata_q, rdata_d;
   logic          run_q, run_d, rst_q, rst_d, wden_q, wden_d;
   logic [18:0]   wdt_q, wdt_d;
   logic [12:0]   wake_q, wake_d;
   logic          stopok_q, stopok_d, divsel_q, divsel_d;
   logic          req;

   // decodes both word addresses; bit 0 = reg one, bit 1 = reg two
   function automatic logic [1:0] decode(input logic [31:0] a);
      decode = {a == `OPT_TWO_ADDR, a == `OPT_ONE_ADDR};
   endfunction

   assign req = hsel && hready && htrans[1];

   always_comb begin
      st_d    = st_q;
      wr_d    = wr_q;
      sel_d   = sel_q;
      rdata_d = rdata_q;
      if (req) begin
         st_d  = BUS_DATA_ST;
         wr_d  = hwrite;
         sel_d = decode(haddr);
         // read data prepared in the address phase, zero if unmapped
         // next values taken so a write in its data phase is seen at once
         case (decode(haddr))
            2'b01:   rdata_d = {24'h000000, one_d};
            2'b10:   rdata_d = {24'h000000, two_d};
            default: rdata_d = 32'h00000000;
         endcase
      end else if (hready) begin
         st_d  = BUS_IDLE_ST;
         wr_d  = 1'b0;
         sel_d = 2'b00;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         st_q    <= BUS_IDLE_ST;
         wr_q    <= 1'b0;
         sel_q   <= 2'b00;
         rdata_q <= 32'h00000000;
      end else begin
         st_q    <= st_d;
         wr_q    <= wr_d;
         sel_q   <= sel_d;
         rdata_q <= rdata_d;
      end
   end

   // ==========================================================
   // write-once option storage
   // ==========================================================
   always_comb begin
      one_d      = one_q;
      two_d      = two_q;
      one_lock_d = one_lock_q;
      two_lock_d = two_lock_q;
      if (st_q == BUS_DATA_ST && wr_q) begin
         // later writes are silently dropped, the bus still says okay
         if (sel_q[0] && !one_lock_q) begin
            one_d      = hwdata[7:0];
            one_lock_d = 1'b1;
         end
         if (sel_q[1] && !two_lock_q) begin
            two_d      = hwdata[7:0];
            two_lock_d = 1'b1;
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         one_q      <= `OPT_ONE_RESET;
         two_q      <= `OPT_TWO_RESET;
         one_lock_q <= 1'b0;
         two_lock_q <= 1'b0;
      end else begin
         one_q      <= one_d;
         two_q      <= two_d;
         one_lock_q <= one_lock_d;
         two_lock_q <= two_lock_d;
      end
   end

   // ==========================================================
   // option decode to the rest of the chip
   // ==========================================================
   always_comb begin
      // monitor runs outside stop; in stop only if asked; never if off
      run_d = !one_q[`BIT_LOWVOLT_PWR_OFF] &&
              (!stop_mode || one_q[`BIT_LOWVOLT_STOP_RUN]);
      rst_d = lowvolt_reset_req && run_d &&
              !one_q[`BIT_LOWVOLT_RST_BLK];
      wden_d = !one_q[`BIT_WATCHDOG_OFF];
      wdt_d  = one_q[`BIT_WATCHDOG_RATE] ? `WDOG_LONG_CYCLES
                                          : `WDOG_SHORT_CYCLES;
      wake_d = one_q[`BIT_SHORT_WAKE] ? `WAKE_SHORT_CYCLES
                                       : `WAKE_LONG_CYCLES;
      stopok_d = one_q[`BIT_STOP_ENABLE];
      // divider reference select; divisor itself lives in the nvm block
      divsel_d = two_q[`BIT_NVM_DIV_CLK_SEL];
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         run_q    <= 1'b1;
         rst_q    <= 1'b0;
         wden_q   <= 1'b1;
         wdt_q    <= `WDOG_SHORT_CYCLES;
         wake_q   <= `WAKE_LONG_CYCLES;
         stopok_q <= 1'b0;
         divsel_q <= 1'b0;
      end else begin
         run_q    <= run_d;
         rst_q    <= rst_d;
         wden_q   <= wden_d;
         wdt_q    <= wdt_d;
         wake_q   <= wake_d;
         stopok_q <= stopok_d;
         divsel_q <= divsel_d;
      end
   end

   assign hrdata              = rdata_q;
   assign hreadyout           = 1'b1;
   assign hresp               = 1'b0;
   assign lowvolt_monitor_run = run_q;
   assign lowvolt_reset_out   = rst_q;
   assign watchdog_enable     = wden_q;
   assign watchdog_timeout    = wdt_q;
   assign wake_delay          = wake_q;
   assign stop_legal          = stopok_q;
   assign nvm_div_use_bus_clk = divsel_q;

   // ==========================================================
   // checks
   // ==========================================================
   property p_write_once;
      @(posedge hclk) disable iff (!hresetn)
      one_lock_q |=> $stable(one_q);
   endproperty
   a_write_once: assert property (p_write_once)
      else $error("option one changed after lock");

   property p_first_write;
      @(posedge hclk) disable iff (!hresetn)
      (st_q == BUS_DATA_ST && wr_q && sel_q[1] && !two_lock_q)
      |=> two_q == $past(hwdata[7:0]) && two_lock_q;
   endproperty
   a_first_write: assert property (p_first_write)
      else $error("first write to option two not stored");

   property p_read_back;
      @(posedge hclk) disable iff (!hresetn)
      (req && !hwrite && haddr == `OPT_ONE_ADDR)
      |=> hrdata == {24'h000000, one_q};
   endproperty
   a_read_back: assert property (p_read_back)
      else $error("option one read data wrong");

   property p_reset_block;
      @(posedge hclk) disable iff (!hresetn)
      one_q[`BIT_LOWVOLT_RST_BLK] |=> !lowvolt_reset_out;
   endproperty
   a_reset_block: assert property (p_reset_block)
      else $error("monitor reset passed while blocked");

   property p_power_off;
      @(posedge hclk) disable iff (!hresetn)
      one_q[`BIT_LOWVOLT_PWR_OFF] |=> !lowvolt_monitor_run;
   endproperty
   a_power_off: assert property (p_power_off)
      else $error("monitor running while powered off");

   property p_stop_run;
      @(posedge hclk) disable iff (!hresetn)
      (stop_mode && !one_q[`BIT_LOWVOLT_PWR_OFF])
      |=> lowvolt_monitor_run == $past(one_q[`BIT_LOWVOLT_STOP_RUN]);
   endproperty
   a_stop_run: assert property (p_stop_run)
      else $error("monitor stop behaviour wrong");

   property p_wake;
      @(posedge hclk) disable iff (!hresetn)
      ##1 wake_delay == ($past(one_q[`BIT_SHORT_WAKE]) ?
                         `WAKE_SHORT_CYCLES : `WAKE_LONG_CYCLES);
   endproperty
   a_wake: assert property (p_wake)
      else $error("wake delay wrong");

   property p_watchdog;
      @(posedge hclk) disable iff (!hresetn)
      ##1 watchdog_timeout == ($past(one_q[`BIT_WATCHDOG_RATE]) ?
                         `WDOG_LONG_CYCLES : `WDOG_SHORT_CYCLES)
      && watchdog_enable == !$past(one_q[`BIT_WATCHDOG_OFF]);
   endproperty
   a_watchdog: assert property (p_watchdog)
      else $error("watchdog setting wrong");

   property p_stop_legal;
      @(posedge hclk) disable iff (!hresetn)
      ##1 stop_legal == $past(one_q[`BIT_STOP_ENABLE]);
   endproperty
   a_stop_legal: assert property (p_stop_legal)
      else $error("stop legality wrong");

   property p_div_sel;
      @(posedge hclk) disable iff (!hresetn)
      ##1 nvm_div_use_bus_clk == $past(two_q[`BIT_NVM_DIV_CLK_SEL]);
   endproperty
   a_div_sel: assert property (p_div_sel)
      else $error("divider clock select wrong");

   property p_write_once_two;
      @(posedge hclk) disable iff (!hresetn)
      two_lock_q |=> $stable(two_q);
   endproperty
   a_write_once_two: assert property (p_write_once_two)
      else $error("option two changed after lock");

   property p_first_write_one;
      @(posedge hclk) disable iff (!hresetn)
      (st_q == BUS_DATA_ST && wr_q && sel_q[0] && !one_lock_q)
      |=> one_q == $past(hwdata[7:0]) && one_lock_q;
   endproperty
   a_first_write_one: assert property (p_first_write_one)
      else $error("first write to option one not stored");

   property p_unmapped_read;
      @(posedge hclk) disable iff (!hresetn)
      (req && !hwrite && decode(haddr) == 2'b00)
      |=> hrdata == 32'h00000000;
   endproperty
   a_unmapped_read: assert property (p_unmapped_read)
      else $error("unmapped read not zero");

   property p_reset_pass;
      @(posedge hclk) disable iff (!hresetn)
      (lowvolt_reset_req && !stop_mode && !one_q[`BIT_LOWVOLT_PWR_OFF] &&
       !one_q[`BIT_LOWVOLT_RST_BLK]) |=> lowvolt_reset_out;
   endproperty
   a_reset_pass: assert property (p_reset_pass)
      else $error("monitor reset not passed");

   property p_powered;
      @(posedge hclk) disable iff (!hresetn)
      (!stop_mode && !one_q[`BIT_LOWVOLT_PWR_OFF]) |=> lowvolt_monitor_run;
   endproperty
   a_powered: assert property (p_powered)
      else $error("monitor off while powered");
endmodule

// ### src/option_regs_map.svh
// offsets, bit positions, reset values and timing counts of the option registers
`ifndef OPTION_REGS_MAP_SVH
`define OPTION_REGS_MAP_SVH

`define OPT_ONE_INDEX        16'h001f
`define OPT_TWO_INDEX        16'h003f
`define OPT_ONE_ADDR         32'h0000007c
`define OPT_TWO_ADDR         32'h000000fc
`define OPT_ONE_RESET        8'h00
`define OPT_TWO_RESET        8'h00

// option_reg_one fields
`define BIT_WATCHDOG_OFF     0
`define BIT_STOP_ENABLE      1
`define BIT_WATCHDOG_RATE    2
`define BIT_SHORT_WAKE       3
`define BIT_LOWVOLT_PWR_OFF  4
`define BIT_LOWVOLT_RST_BLK  5
`define BIT_LOWVOLT_STOP_RUN 6
// option_reg_two fields
`define BIT_NVM_DIV_CLK_SEL  0

// oscillator cycles
`define WAKE_SHORT_CYCLES    13'd32
`define WAKE_LONG_CYCLES     13'd4096
`define WDOG_LONG_CYCLES     19'd262128
`define WDOG_SHORT_CYCLES    19'd8176

`endif

// ### src/option_regs_pkg.sv
// types shared by the option register bank
package option_regs_pkg;
   typedef enum logic [1:0] {
      BUS_IDLE_ST = 2'b01,
      BUS_DATA_ST = 2'b10
   } bus_state_type;
   typedef logic [7:0] opt_byte_type;
endpackage

// ### verif/tb.sv
// self-checking bench for the write-once startup option registers
`timescale 1ns/1ps
`include "option_regs_map.svh"

module tb;
   import option_regs_pkg::*;
   // ==========================================
   // stimulus and design hookup
   logic        hclk;
   logic        hresetn;
   logic        hsel;
   logic [31:0] haddr;
   logic [1:0]  htrans;
   logic        hwrite;
   logic [2:0]  hsize;
   logic [31:0] hwdata;
   wire  logic  hready;
   logic [31:0] hrdata;
   logic        hreadyout;
   logic        hresp;
   logic        stop_mode;
   logic        lowvolt_reset_req;
   logic        lowvolt_monitor_run;
   logic        lowvolt_reset_out;
   logic        watchdog_enable;
   logic [18:0] watchdog_timeout;
   logic [12:0] wake_delay;
   logic        stop_legal;
   logic        nvm_div_use_bus_clk;
   integer      seed = 32'h29c19e53;
   integer      fails = 0;
   integer      checked = 0;
   integer      cycles = 0;
   // single slave, so its ready is the bus ready
   assign hready = hreadyout;

   startup_option_registers u_startup_option_registers (
      .hclk                (hclk),
      .hresetn             (hresetn),
      .hsel                (hsel),
      .haddr               (haddr),
      .htrans              (htrans),
      .hwrite              (hwrite),
      .hsize               (hsize),
      .hwdata              (hwdata),
      .hready              (hready),
      .hrdata              (hrdata),
      .hreadyout           (hreadyout),
      .hresp               (hresp),
      .stop_mode           (stop_mode),
      .lowvolt_reset_req   (lowvolt_reset_req),
      .lowvolt_monitor_run (lowvolt_monitor_run),
      .lowvolt_reset_out   (lowvolt_reset_out),
      .watchdog_enable     (watchdog_enable),
      .watchdog_timeout    (watchdog_timeout),
      .wake_delay          (wake_delay),
      .stop_legal          (stop_legal),
      .nvm_div_use_bus_clk (nvm_div_use_bus_clk)
   );

   always #20 hclk = ~hclk;

   // ==========================================
   // reporting
   task automatic tally_and_finish();
      $display("checked %0d fails %0d", checked, fails);
      if (fails == 0 && checked > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   task automatic check(input string what, input logic [31:0] seen, exp);
      checked++;
      if (seen !== exp) begin
         fails++;
         $display("unexpected %s expected %h seen %h", what, exp, seen);
      end
   endtask

   // hang guard, far above the few hundred cycles the run needs
   always @(posedge hclk) begin
      cycles++;
      if (cycles == 5000) begin
         fails++;
         tally_and_finish();
      end
   end

   // ==========================================
   // bus and reset tasks, entered just after a rising edge
   task automatic bus(input logic wr, input logic [31:0] a, wd,
                      output logic [31:0] rd);
      hsel   <= 1'b1;
      htrans <= 2'b10;
      haddr  <= a;
      hwrite <= wr;
      // each phase holds until ready is seen high at a rising edge
      do @(posedge hclk); while (hready !== 1'b1);
      hsel   <= 1'b0;
      htrans <= 2'b00;
      hwdata <= wd;
      do @(posedge hclk); while (hready !== 1'b1);
      rd = hrdata;
   endtask

   task automatic do_reset();
      hresetn <= 1'b0;
      repeat (4) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
   endtask

   // monitor is powered unless switched off; in stop only if asked to run
   function automatic logic exp_run(input opt_byte_type r1,
                                    input logic stop);
      exp_run = !r1[`BIT_LOWVOLT_PWR_OFF] &&
                (!stop || r1[`BIT_LOWVOLT_STOP_RUN]);
   endfunction

   // option outputs worked out from the stored bytes and the side inputs
   task automatic check_outs(input opt_byte_type r1, r2);
      stop_mode         <= 1'($random(seed));
      lowvolt_reset_req <= 1'($random(seed));
      repeat (3) @(posedge hclk);
      @(negedge hclk);
      check("monitor run", lowvolt_monitor_run,
            exp_run(r1, stop_mode));
      check("monitor reset", lowvolt_reset_out,
            exp_run(r1, stop_mode) && lowvolt_reset_req &&
            !r1[`BIT_LOWVOLT_RST_BLK]);
      check("watchdog enable", watchdog_enable,
            !r1[`BIT_WATCHDOG_OFF]);
      check("watchdog timeout", watchdog_timeout,
            r1[`BIT_WATCHDOG_RATE] ? `WDOG_LONG_CYCLES
                                   : `WDOG_SHORT_CYCLES);
      check("wake delay", wake_delay,
            r1[`BIT_SHORT_WAKE] ? `WAKE_SHORT_CYCLES
                                : `WAKE_LONG_CYCLES);
      check("stop legal", stop_legal, r1[`BIT_STOP_ENABLE]);
      check("nvm clock", nvm_div_use_bus_clk,
            r2[`BIT_NVM_DIV_CLK_SEL]);
      @(posedge hclk);
   endtask

   // ==========================================
   // main sequence
   initial begin
      logic [31:0]  rd;
      opt_byte_type r1;
      opt_byte_type r2;
      hclk = 1'b0;
      hresetn = 1'b0;
      hsel = 1'b0;
      haddr = 32'h0;
      htrans = 2'b00;
      hwrite = 1'b0;
      hsize = 3'b010;
      hwdata = 32'h0;
      stop_mode = 1'b0;
      lowvolt_reset_req = 1'b0;
      @(posedge hclk);
      // each pass starts from a reset taken after the previous writes
      for (int i = 0; i < 8; i++) begin
         do_reset();
         check_outs(8'h00, 8'h00);
         bus(1'b0, `OPT_ONE_ADDR, 32'h0, rd);
         check("reg one reset", rd, 32'h0);
         bus(1'b0, `OPT_TWO_ADDR, 32'h0, rd);
         check("reg two reset", rd, 32'h0);
         // corner bytes first: all ones, then a zero write that still locks
         r1 = (i == 0) ? 8'hff : (i == 1) ? 8'h00 : 8'($random(seed));
         r2 = (i == 0) ? 8'hff : (i == 1) ? 8'h00 : 8'($random(seed));
         // pass 2 stands for a crystal-clocked system: short wake clear
         if (i == 2) r1[`BIT_SHORT_WAKE] = 1'b0;
         bus(1'b1, `OPT_ONE_ADDR, {24'($random(seed)), r1}, rd);
         bus(1'b0, `OPT_ONE_ADDR, 32'h0, rd);
         check("reg one written", rd, {24'h0, r1});
         bus(1'b0, `OPT_TWO_ADDR, 32'h0, rd);
         check("reg two untouched", rd, 32'h0);
         bus(1'b1, 32'h00000080, $random(seed), rd);
         bus(1'b0, 32'h00000080, 32'h0, rd);
         check("unmapped read", rd, 32'h0);
         bus(1'b1, `OPT_TWO_ADDR, {24'($random(seed)), r2}, rd);
         bus(1'b1, `OPT_ONE_ADDR, {24'h0, ~r1}, rd);
         bus(1'b1, `OPT_TWO_ADDR, {24'h0, ~r2}, rd);
         bus(1'b0, `OPT_ONE_ADDR, 32'h0, rd);
         check("reg one locked", rd, {24'h0, r1});
         bus(1'b0, `OPT_TWO_ADDR, 32'h0, rd);
         check("reg two locked", rd, {24'h0, r2});
         check("bus response", hresp, 1'b0);
         check_outs(r1, r2);
         check_outs(r1, r2);
      end
      tally_and_finish();
   end
endmodule
